//--- usb_device_address_and_global_irq.sv
`timescale 1ns/100ps
// Behaviour
// - Function enable is cleared at power-up; once set, firmware writes cannot clear it.
// - Address field is forced to zero after power-up and every USB bus reset.
// - Address register reads all zeros after hardware reset.
// - Wake-up flag sets when a suspended bus goes non-idle, not by upstream resume.
// - End-of-reset flag sets when the end of a bus reset is seen.
// - Start-of-frame flag sets on each correctly received start-of-frame packet.
// - Suspend flag sets when the bus stays idle for 3 ms.
// - USB interrupt asserts when any flag is set with its enable set.
// - Reserved flag and enable bits read zero; writes to them are ignored.
// - Enable register resets to 0x10, end-of-reset enable only.
// - Each enable bit gates only its own event onto the interrupt.
// - Bus reset is single-ended zero held at least 32 full-speed bit times.
module usb_device_address_and_global_irq #(
    parameter int SUSPEND_CYCLES = usb_glob_pkg::SUSPEND_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       usb_se0,
    input  wire logic       usb_idle,
    input  wire logic       sof_received,
    input  wire logic       upstream_resume,
    output logic            usb_irq,
    output logic            function_enable,
    output logic      [6:0] device_address_field,
    output logic            bus_reset_active,
    output logic            usb_suspended
);
    localparam int RST_CYC = usb_glob_pkg::RESET_CYCLES;
    localparam int SE0_W   = $clog2(RST_CYC + 1);
    localparam int IDLE_W  = $clog2(SUSPEND_CYCLES + 1);
    localparam logic [SE0_W-1:0]  SE0_SAT  = SE0_W'(RST_CYC);
    localparam logic [IDLE_W-1:0] IDLE_SAT = IDLE_W'(SUSPEND_CYCLES);
    localparam logic [IDLE_W-1:0] IDLE_ONE = IDLE_W'(1);
    localparam logic [SE0_W-1:0]  SE0_ONE  = SE0_W'(1);

    // ==========================================================
    // Bus line monitor
    typedef enum logic [2:0] {
        LINK_ACTIVE  = 3'b001,
        LINK_RESET   = 3'b010,
        LINK_SUSPEND = 3'b100
    } link_state_type;

    link_state_type        link_reg;
    link_state_type        link_next;
    logic [SE0_W-1:0]      se0_cnt_reg;
    logic [SE0_W-1:0]      se0_cnt_next;
    logic [IDLE_W-1:0]     idle_cnt_reg;
    logic [IDLE_W-1:0]     idle_cnt_next;
    logic                  eor_evt;
    logic                  susp_evt;
    logic                  wake_evt;

    always_comb begin
        link_next     = link_reg;
        se0_cnt_next  = '0;
        idle_cnt_next = '0;
        eor_evt       = 1'b0;
        susp_evt      = 1'b0;
        wake_evt      = 1'b0;
        if (usb_se0) begin
            // Saturating count keeps the counter narrow during long resets
            se0_cnt_next = (se0_cnt_reg == SE0_SAT) ? se0_cnt_reg : se0_cnt_reg + SE0_ONE;
        end
        case (link_reg)
            LINK_ACTIVE: begin
                if (usb_se0 && se0_cnt_next == SE0_SAT) begin
                    link_next = LINK_RESET;
                end else if (usb_idle) begin
                    idle_cnt_next = idle_cnt_reg + IDLE_ONE;
                    if (idle_cnt_next == IDLE_SAT) begin
                        susp_evt  = 1'b1;
                        link_next = LINK_SUSPEND;
                    end
                end
            end
            LINK_RESET: begin
                if (!usb_se0) begin
                    eor_evt   = 1'b1;
                    link_next = LINK_ACTIVE;
                end
            end
            LINK_SUSPEND: begin
                if (!usb_idle) begin
                    // Own resume signalling must not count as a wake-up
                    wake_evt  = !upstream_resume;
                    link_next = LINK_ACTIVE;
                end
            end
            default: begin
                link_next = LINK_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_reg     <= LINK_ACTIVE;
            se0_cnt_reg  <= '0;
            idle_cnt_reg <= '0;
        end else begin
            link_reg     <= link_next;
            se0_cnt_reg  <= se0_cnt_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    assign bus_reset_active = (link_reg == LINK_RESET);
    assign usb_suspended    = (link_reg == LINK_SUSPEND);

    // ==========================================================
    // Event flags
    logic       wr_flags;
    logic [7:0] clr_bits;
    logic       wakeup_flag;
    logic       end_of_reset_flag;
    logic       frame_start_flag;
    logic       suspend_flag;

    // Firmware clears a flag by writing zero to it; ones are ignored
    assign wr_flags = sfr_wr && sfr_addr == usb_glob_pkg::FLAGS_ADDR;
    assign clr_bits = wr_flags ? ~sfr_wdata : 8'h00;

    usb_sticky_flag u_wakeup (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (wake_evt),
        .clr      (clr_bits[usb_glob_pkg::WAKEUP_BIT]),
        .q        (wakeup_flag)
    );
    usb_sticky_flag u_eor (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (eor_evt),
        .clr      (clr_bits[usb_glob_pkg::EOR_BIT]),
        .q        (end_of_reset_flag)
    );
    usb_sticky_flag u_sof (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (sof_received),
        .clr      (clr_bits[usb_glob_pkg::SOF_BIT]),
        .q        (frame_start_flag)
    );
    usb_sticky_flag u_suspend (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (susp_evt),
        .clr      (clr_bits[usb_glob_pkg::SUSPEND_BIT]),
        .q        (suspend_flag)
    );

    logic [7:0] flags;
    always_comb begin
        flags = 8'h00;
        flags[usb_glob_pkg::WAKEUP_BIT]  = wakeup_flag;
        flags[usb_glob_pkg::EOR_BIT]     = end_of_reset_flag;
        flags[usb_glob_pkg::SOF_BIT]     = frame_start_flag;
        flags[usb_glob_pkg::SUSPEND_BIT] = suspend_flag;
    end

    // ==========================================================
    // Enables, address and read port
    logic [7:0] enables_reg;
    logic [7:0] enables_next;
    logic       fen_reg;
    logic       fen_next;
    logic [6:0] addr_reg;
    logic [6:0] addr_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       wr_addr;

    assign wr_addr = sfr_wr && sfr_addr == usb_glob_pkg::ADDRESS_ADDR;

    always_comb begin
        enables_next = enables_reg;
        fen_next     = fen_reg | (wr_addr & sfr_wdata[usb_glob_pkg::FEN_BIT]);
        addr_next    = addr_reg;
        rdata_next   = rdata_reg;
        if (sfr_wr && sfr_addr == usb_glob_pkg::ENABLES_ADDR) begin
            enables_next = sfr_wdata & usb_glob_pkg::EVENT_MASK;
        end
        if (wr_addr) begin
            addr_next = sfr_wdata[usb_glob_pkg::ADDR_MSB:0];
        end
        if (link_next == LINK_RESET || bus_reset_active) begin
            addr_next = usb_glob_pkg::DEFAULT_ADDR;
        end
        if (sfr_rd) begin
            case (sfr_addr)
                usb_glob_pkg::FLAGS_ADDR:   rdata_next = flags;
                usb_glob_pkg::ENABLES_ADDR: rdata_next = enables_reg;
                usb_glob_pkg::ADDRESS_ADDR: rdata_next = {fen_reg, addr_reg};
                default:                    rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enables_reg <= usb_glob_pkg::ENABLES_RESET;
            fen_reg     <= 1'b0;
            addr_reg    <= usb_glob_pkg::DEFAULT_ADDR;
            rdata_reg   <= 8'h00;
        end else begin
            enables_reg <= enables_next;
            fen_reg     <= fen_next;
            addr_reg    <= addr_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign usb_irq              = |(flags & enables_reg);
    assign function_enable      = fen_reg;
    assign device_address_field = addr_reg;
    assign sfr_rdata            = rdata_reg;

    // ==========================================================
    // Checks
    // Own run length of single-ended zero, so the reset check does not unroll a long repeat
    logic [SE0_W-1:0] se0_run_reg;
    logic [SE0_W-1:0] se0_run_next;

    always_comb begin
        se0_run_next = '0;
        if (usb_se0) begin
            se0_run_next = (se0_run_reg == SE0_SAT) ? se0_run_reg : se0_run_reg + SE0_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            se0_run_reg <= '0;
        end else begin
            se0_run_reg <= se0_run_next;
        end
    end

    fen_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(fen_reg) |-> fen_reg) else $error("function enable dropped");
    addr_default_a: assert property (@(posedge core_clk) disable iff (rst)
        bus_reset_active |-> addr_reg == 7'h00) else $error("address not forced");
    reset_values_a: assert property (@(posedge core_clk)
        rst |=> {fen_reg, addr_reg} == 8'h00 && enables_reg == 8'h10 && flags == 8'h00)
        else $error("bad reset values");
    wake_set_a: assert property (@(posedge core_clk) disable iff (rst)
        usb_suspended && !usb_idle && !upstream_resume |=> wakeup_flag)
        else $error("wake-up flag missed");
    wake_own_a: assert property (@(posedge core_clk) disable iff (rst)
        !wakeup_flag && !(usb_suspended && !usb_idle && !upstream_resume) |=> !wakeup_flag)
        else $error("spurious wake-up flag");
    eor_set_a: assert property (@(posedge core_clk) disable iff (rst)
        bus_reset_active && !usb_se0 |=> end_of_reset_flag && !bus_reset_active)
        else $error("end of reset missed");
    sof_set_a: assert property (@(posedge core_clk) disable iff (rst)
        sof_received |=> frame_start_flag) else $error("frame start missed");
    reset_detect_a: assert property (@(posedge core_clk) disable iff (rst)
        usb_se0 && se0_run_reg == SE0_SAT - SE0_ONE && !usb_suspended |=> bus_reset_active)
        else $error("bus reset not detected");
    short_se0_a: assert property (@(posedge core_clk) disable iff (rst)
        !bus_reset_active && !usb_se0 ##1 usb_se0 [*8] |-> !bus_reset_active)
        else $error("short se0 taken as reset");
    hw_no_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        suspend_flag && !clr_bits[0] |=> suspend_flag) else $error("flag lost");
    irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        usb_irq == ((wakeup_flag && enables_reg[5]) || (end_of_reset_flag && enables_reg[4])
        || (frame_start_flag && enables_reg[3]) || (suspend_flag && enables_reg[0])))
        else $error("interrupt gating wrong");
    rsvd_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        (enables_reg & 8'hC6) == 8'h00) else $error("reserved enable bit set");

    suspend_c: cover property (@(posedge core_clk) disable iff (rst) susp_evt);
    wake_c:    cover property (@(posedge core_clk) disable iff (rst) wake_evt);
    eor_c:     cover property (@(posedge core_clk) disable iff (rst) eor_evt ##1 usb_irq);
    clr_set_c: cover property (@(posedge core_clk) disable iff (rst)
        sof_received && clr_bits[usb_glob_pkg::SOF_BIT]);
endmodule

//--- usb_device_address_and_global_irq_tb_top.sv
`timescale 1ns/100ps
module usb_device_address_and_global_irq_tb_top;
    logic       core_clk, rst, sfr_wr, sfr_rd, upstream_resume;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic       usb_se0, usb_idle, sof_received, usb_irq, function_enable;
    logic [6:0] device_address_field;
    logic       bus_reset_active, usb_suspended;
    int         err_count, num_checks, cycles;

    usb_device_address_and_global_irq #(.SUSPEND_CYCLES(20)) uut (
        .core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .usb_se0(usb_se0), .usb_idle(usb_idle), .sof_received(sof_received),
        .upstream_resume(upstream_resume), .usb_irq(usb_irq),
        .function_enable(function_enable), .device_address_field(device_address_field),
        .bus_reset_active(bus_reset_active), .usb_suspended(usb_suspended));

    usb_host_model host (.core_clk(core_clk), .usb_se0(usb_se0), .usb_idle(usb_idle),
        .sof_received(sof_received));

    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge core_clk);
        #1 sfr_wr = 1'b0;
    endtask

    // Read data is registered, so it is judged one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1 sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge core_clk);
        #1 sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values();
        rd(8'hBD, 8'h00);
        rd(8'hBE, 8'h10);
        rd(8'hC6, 8'h00);
        chk(usb_irq, 8'h00);
    endtask

    task automatic t_bus_reset();
        host.hold(1'b1, 1'b0, 20);
        chk(bus_reset_active, 8'h00);
        host.hold(1'b0, 1'b0, 2);
        rd(8'hBD, 8'h00);
        host.hold(1'b1, 1'b0, 60);
        chk(bus_reset_active, 8'h01);
        chk(device_address_field, 8'h00);
        host.hold(1'b0, 1'b0, 2);
        chk(bus_reset_active, 8'h00);
        rd(8'hBD, 8'h10);
        chk(usb_irq, 8'h01);
    endtask

    task automatic t_address();
        wr(8'hC6, 8'h85);
        chk(function_enable, 8'h01);
        rd(8'hC6, 8'h85);
        wr(8'hC6, 8'h2A);
        chk(function_enable, 8'h01);
        chk(device_address_field, 8'h2A);
        host.hold(1'b1, 1'b0, 60);
        host.hold(1'b0, 1'b0, 2);
        rd(8'hC6, 8'h80);
    endtask

    task automatic t_flags();
        wr(8'hBD, 8'h00);
        rd(8'hBD, 8'h00);
        chk(usb_irq, 8'h00);
        host.sof_pulse();
        rd(8'hBD, 8'h08);
        chk(usb_irq, 8'h00);
        wr(8'hBE, 8'h39);
        rd(8'hBE, 8'h39);
        chk(usb_irq, 8'h01);
        wr(8'hBD, 8'h39);
        rd(8'hBD, 8'h08);
    endtask

    // Wake-up is only credited to the host, never to our own resume
    task automatic t_suspend();
        wr(8'hBD, 8'h00);
        host.hold(1'b0, 1'b1, 25);
        chk(usb_suspended, 8'h01);
        rd(8'hBD, 8'h01);
        host.hold(1'b0, 1'b0, 3);
        chk(usb_suspended, 8'h00);
        rd(8'hBD, 8'h21);
        wr(8'hBD, 8'h00);
        host.hold(1'b0, 1'b1, 25);
        upstream_resume = 1'b1;
        host.hold(1'b0, 1'b0, 3);
        rd(8'hBD, 8'h01);
        upstream_resume = 1'b0;
    endtask

    task automatic t_gating();
        int bits[4];
        bits = '{0, 3, 4, 5};
        host.sof_pulse();
        host.hold(1'b1, 1'b0, 60);
        host.hold(1'b0, 1'b0, 2);
        rd(8'hBD, 8'h19);
        foreach (bits[k]) begin
            wr(8'hBE, 8'h01 << bits[k]);
            chk(usb_irq, (bits[k] != 5) ? 8'h01 : 8'h00);
        end
        wr(8'hBE, 8'h00);
        chk(usb_irq, 8'h00);
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        upstream_resume = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        t_reset_values();
        t_bus_reset();
        t_address();
        t_flags();
        t_suspend();
        t_gating();
        results();
    end
endmodule

//--- usb_glob_pkg.sv
package usb_glob_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] FLAGS_ADDR   = 8'hBD;
    localparam logic [7:0] ENABLES_ADDR = 8'hBE;
    localparam logic [7:0] ADDRESS_ADDR = 8'hC6;

    // ==========================================================
    // Field positions
    localparam int WAKEUP_BIT   = 5;
    localparam int EOR_BIT      = 4;
    localparam int SOF_BIT      = 3;
    localparam int SUSPEND_BIT  = 0;
    localparam int FEN_BIT      = 7;
    localparam int ADDR_MSB     = 6;
    localparam logic [7:0] EVENT_MASK = 8'h39;

    // ==========================================================
    // Reset values
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h10;
    localparam logic [7:0] ADDRESS_RESET = 8'h00;
    localparam logic [6:0] DEFAULT_ADDR  = 7'h00;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 50000;
    localparam int CLK_MHZ         = 20;
    localparam int FS_BIT_PS       = 83333;
    localparam int RESET_BITS      = 32;
    localparam int RESET_CYCLES    =
        (RESET_BITS * FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SUSPEND_US      = 3000;
    localparam int SUSPEND_CYCLES  = SUSPEND_US * CLK_MHZ;

endpackage

//--- usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model (
    input  wire logic core_clk,
    output logic      usb_se0,
    output logic      usb_idle,
    output logic      sof_received
);
    // ==========================================================
    // Line state starts as active traffic, not idle and not in reset
    initial begin
        usb_se0      = 1'b0;
        usb_idle     = 1'b0;
        sof_received = 1'b0;
    end

    // ==========================================================
    // Hold a line state for n edges; a long single-ended zero is a bus reset
    task automatic hold(input logic s, input logic i, input int n);
        @(posedge core_clk);
        #1 usb_se0 = s;
        usb_idle = i;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic sof_pulse();
        @(posedge core_clk);
        #1 sof_received = 1'b1;
        @(posedge core_clk);
        #1 sof_received = 1'b0;
    endtask
endmodule

//--- usb_sticky_flag.sv
`timescale 1ns/100ps
module usb_sticky_flag (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    logic q_reg;
    logic q_next;

    // Set beats clear so an event landing on the clear write is kept
    always_comb begin
        q_next = q_reg;
        if (clr) begin
            q_next = 1'b0;
        end
        if (set) begin
            q_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
